/* verilog/timer_pkg.sv */
// Package: register map, field layout, reset values and shared types of the timer
package timer_pkg;
   // Register indices; the bus byte address is four times the index
   localparam logic [11:0] IDX_COUNT_LOW = 12'hFD2;
   localparam logic [11:0] IDX_COUNT_HIGH_PERIOD = 12'hFD3;
   localparam logic [11:0] IDX_CONTROL_ENABLE_MODE_DIVIDER = 12'hFD4;
   localparam logic [11:0] IDX_CONTROL_CLOCK_PRESCALE = 12'hFD5;
   localparam logic [11:0] IDX_IRQ_CTRL = 12'hFD6;
   localparam int ADDR_W = 14;
   // Field positions of the first control register
   localparam int MODULE_ENABLE_BIT = 7;
   localparam int OUTPUT_LEVEL_STATUS_BIT = 5;
   localparam int WIDE_COUNTER_SELECT_BIT = 4;
   localparam int OUTPUT_DIVIDER_LSB = 0;
   // Field positions of the second control register
   localparam int CLOCK_SOURCE_LSB = 5;
   localparam int INPUT_UNSYNC_BIT = 4;
   localparam int INPUT_PRESCALE_LSB = 0;
   // Field positions of the interrupt control register
   localparam int IRQ_FLAG_BIT = 0;
   localparam int IRQ_ENABLE_BIT = 1;
   // Reset values
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   // Input prescaler counter width (up to 1:32768)
   localparam int PRESCALE_W = 15;
   // Clock source codes
   typedef enum logic [2:0] {
      CS_PIN = 3'h0, CS_PIN_INV = 3'h1, CS_INSTR = 3'h2, CS_HF_OSC = 3'h3,
      CS_LF_OSC = 3'h4, CS_SEC_OSC = 3'h5, CS_MF_OSC = 3'h6, CS_LOGIC_CELL = 3'h7
   } clock_source_e;
   // Raw clock inputs of the counter, sampled by ref_clk
   typedef struct packed {
      logic pin;
      logic hf_osc;
      logic lf_osc;
      logic sec_osc;
      logic mf_osc;
      logic logic_cell;
   } clock_inputs_s;
endpackage : timer_pkg

/* verilog/timer0_output_postscaler_ctrl.sv */
// Timer with period match, 16-bit rollover, output postscaler and Avalon-MM registers
// Operation
// - Postscaler hidden; cleared by writes, reset
// - Output toggles on match or rollover
// - Output level readable at bit 5
// - Timer output offered to pin selection
// - Flag set on toggle; enable raises interrupt
// - Flag set every N+1 events
// - Synchronous timer stops during sleep
// - Asynchronous timer runs, wakes on interrupt
// - Bit 7 enables module, resets 0
// - Bit 4 selects 16-bit or 8-bit
// - Bits 3:0 select postscale value plus one
// - Bits 7:5 select clock source, reset 0
// - Bit 4 disables input synchronisation
// - Bits 3:0 select power-of-two prescale
// - 8-bit: high register is period
// - 16-bit: high/low bytes, reset zero
// - Buffered period compared, reloaded on match
// - Low read latches high; low write loads
// - Clock source code decode
// - Prescaler cleared by writes and reset
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module timer0_output_postscaler_ctrl
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [timer_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire timer_pkg::clock_inputs_s clock_inputs,
   input wire logic sleep_mode,
   output logic timer_output,
   output logic timer_irq,
   output logic wake_request
);
   import timer_pkg::*;

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [7:0] count_low;
   logic [7:0] count_high_period;
   logic [7:0] count_high;
   logic [7:0] period_buffer;
   logic module_enable;
   logic wide_counter_select;
   logic [3:0] output_divider_select;
   logic [2:0] clock_source_select;
   logic input_unsync_select;
   logic [3:0] input_prescale_select;
   logic timer_irq_flag;
   logic timer_irq_enable;
   logic [PRESCALE_W-1:0] prescale_count;
   logic [3:0] postscale_count;
   logic src_sync1;
   logic src_sync2;
   logic src_prev;
   logic access_done;

   // ----------------------------------------------------------------
   // Bus decode: one wait state, answered on the second cycle
   // ----------------------------------------------------------------
   logic [11:0] reg_index;
   logic hit;
   logic wr_go;
   logic rd_go;
   logic wr_low;
   logic wr_high;
   logic wr_con0;
   logic wr_con1;
   logic wr_irq;
   logic rd_low;
   logic [7:0] wbyte;

   assign reg_index = avs_address[ADDR_W-1:2];
   assign hit = avs_address[1:0] == 2'h0;
   assign wr_go = avs_write && access_done && hit && avs_byteenable[0];
   assign rd_go = avs_read && access_done && hit;
   assign wbyte = avs_writedata[7:0];
   assign wr_low = wr_go && reg_index == IDX_COUNT_LOW;
   assign wr_high = wr_go && reg_index == IDX_COUNT_HIGH_PERIOD;
   assign wr_con0 = wr_go && reg_index == IDX_CONTROL_ENABLE_MODE_DIVIDER;
   assign wr_con1 = wr_go && reg_index == IDX_CONTROL_CLOCK_PRESCALE;
   assign wr_irq = wr_go && reg_index == IDX_IRQ_CTRL;
   assign rd_low = rd_go && reg_index == IDX_COUNT_LOW;

   // Wait state toggle: request held by master until waitrequest low
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         access_done <= 1'b0;
         avs_waitrequest <= 1'b1;
      end
      else
      begin
         access_done <= (avs_read || avs_write) && !access_done;
         avs_waitrequest <= !((avs_read || avs_write) && !access_done);
      end
   end

   // ----------------------------------------------------------------
   // Clock source selection and edge detection
   // ----------------------------------------------------------------
   logic src_raw;
   logic src_level;
   logic instr_tick;
   logic [1:0] instr_div;

   always_comb
   begin
      unique case (clock_source_e'(clock_source_select))
         CS_PIN: src_raw = clock_inputs.pin;
         CS_PIN_INV: src_raw = !clock_inputs.pin;
         CS_INSTR: src_raw = instr_div[1];
         CS_HF_OSC: src_raw = clock_inputs.hf_osc;
         CS_LF_OSC: src_raw = clock_inputs.lf_osc;
         CS_SEC_OSC: src_raw = clock_inputs.sec_osc;
         CS_MF_OSC: src_raw = clock_inputs.mf_osc;
         CS_LOGIC_CELL: src_raw = clock_inputs.logic_cell;
      endcase
   end

   // Instruction clock: system clock divided by four
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         instr_div <= 2'h0;
      else
         instr_div <= instr_div + 2'h1;
   end
   assign instr_tick = instr_div == 2'h3;

   // Two-stage capture; only the second stage feeds the edge detect
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         src_sync1 <= 1'b0;
         src_sync2 <= 1'b0;
      end
      else
      begin
         src_sync1 <= src_raw;
         src_sync2 <= src_sync1;
      end
   end
   assign src_level = src_sync2;

   // Edge memory: a sync edge waits for the next tick, so a quarter-rate source is not lost
   logic sync_edge;
   logic rise;
   logic edge_pending;
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         src_prev <= 1'b0;
         edge_pending <= 1'b0;
      end
      else
      begin
         src_prev <= src_level;
         edge_pending <= !instr_tick && (edge_pending || (src_level && !src_prev));
      end
   end
   assign sync_edge = instr_tick && (edge_pending || (src_level && !src_prev));

   // synchronised or free input; sleep halts sync; async keeps running
   assign rise = input_unsync_select ? (src_level && !src_prev) : (sync_edge && !sleep_mode);

   // ----------------------------------------------------------------
   // Input prescaler
   // ----------------------------------------------------------------
   logic [PRESCALE_W:0] prescale_limit;
   logic count_tick;
   logic ctl_clear;

   assign ctl_clear = wr_low || wr_con0 || wr_con1;
   // ratio is two to the select
   assign prescale_limit = (PRESCALE_W+1)'(1) << input_prescale_select;
   assign count_tick = module_enable && rise &&
      ({1'b0, prescale_count} == prescale_limit - (PRESCALE_W+1)'(1));

   // prescaler cleared by writes and reset
   always_ff @(posedge ref_clk)
   begin
      if (rst || ctl_clear)
         prescale_count <= '0;
      else if (module_enable && rise)
         prescale_count <= count_tick ? '0 : prescale_count + PRESCALE_W'(1);
   end

   // ----------------------------------------------------------------
   // Counter core
   // ----------------------------------------------------------------
   logic match_8;
   logic roll_16;
   logic timer_event;

   assign match_8 = !wide_counter_select && count_low == period_buffer;
   assign roll_16 = wide_counter_select && count_low == 8'hFF && count_high == 8'hFF;
   assign timer_event = count_tick && (match_8 || roll_16);

   // Low count: bus write wins over the count
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         count_low <= COUNT_RESET;
      else if (wr_low)
         count_low <= wbyte;
      else if (count_tick && match_8)
         count_low <= 8'h00;
      else if (count_tick)
         count_low <= count_low + 8'h01;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         count_high <= COUNT_RESET;
      else if (wr_low)
         count_high <= count_high_period;
      else if (count_tick && wide_counter_select && count_low == 8'hFF)
         count_high <= count_high + 8'h01;
   end

   // High/period register
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         count_high_period <= COUNT_RESET;
      else if (wr_high)
         count_high_period <= wbyte;
      else if (rd_low && wide_counter_select)
         count_high_period <= count_high;
   end

   // buffer reload on match; idle module tracks the register
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         period_buffer <= COUNT_RESET;
      else if ((count_tick && match_8) || !module_enable)
         period_buffer <= count_high_period;
   end

   // ----------------------------------------------------------------
   // Output postscaler and output level
   // ----------------------------------------------------------------
   // advance per event, wrap at ratio; ratio is value plus one
   always_ff @(posedge ref_clk)
   begin
      if (rst || ctl_clear)
         postscale_count <= 4'h0;
      else if (timer_event)
         postscale_count <= (postscale_count == output_divider_select) ? 4'h0 : postscale_count + 4'h1;
   end

   logic out_toggle;
   assign out_toggle = timer_event && postscale_count == output_divider_select;

   // toggle on divided event; drives pin selection
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         timer_output <= 1'b0;
      else if (out_toggle)
         timer_output <= !timer_output;
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   // enable, width, divider
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         module_enable <= CONTROL_RESET[MODULE_ENABLE_BIT];
         wide_counter_select <= CONTROL_RESET[WIDE_COUNTER_SELECT_BIT];
         output_divider_select <= CONTROL_RESET[OUTPUT_DIVIDER_LSB +: 4];
      end
      else if (wr_con0)
      begin
         module_enable <= wbyte[MODULE_ENABLE_BIT];
         wide_counter_select <= wbyte[WIDE_COUNTER_SELECT_BIT];
         output_divider_select <= wbyte[OUTPUT_DIVIDER_LSB +: 4];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         clock_source_select <= CONTROL_RESET[CLOCK_SOURCE_LSB +: 3];
         input_unsync_select <= CONTROL_RESET[INPUT_UNSYNC_BIT];
         input_prescale_select <= CONTROL_RESET[INPUT_PRESCALE_LSB +: 4];
      end
      else if (wr_con1)
      begin
         clock_source_select <= wbyte[CLOCK_SOURCE_LSB +: 3];
         input_unsync_select <= wbyte[INPUT_UNSYNC_BIT];
         input_prescale_select <= wbyte[INPUT_PRESCALE_LSB +: 4];
      end
   end

   // ----------------------------------------------------------------
   // Interrupt flag, enable and wake
   // ----------------------------------------------------------------
   // set on toggle; the set wins over a software clear
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         timer_irq_flag <= 1'b0;
         timer_irq_enable <= 1'b0;
      end
      else
      begin
         if (out_toggle)
            timer_irq_flag <= 1'b1;
         else if (wr_irq)
            timer_irq_flag <= wbyte[IRQ_FLAG_BIT];
         if (wr_irq)
            timer_irq_enable <= wbyte[IRQ_ENABLE_BIT];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         timer_irq <= 1'b0;
         wake_request <= 1'b0;
      end
      else
      begin
         timer_irq <= timer_irq_flag && timer_irq_enable;
         wake_request <= timer_irq_flag && timer_irq_enable && sleep_mode;
      end
   end

   // ----------------------------------------------------------------
   // Read data, registered on the edge that first sees the request
   // ----------------------------------------------------------------
   logic [7:0] next_rbyte;
   always_comb
   begin
      next_rbyte = 8'h00;
      if (hit)
      begin
         unique case (reg_index)
            IDX_COUNT_LOW: next_rbyte = count_low;
            IDX_COUNT_HIGH_PERIOD: next_rbyte = count_high_period;
            IDX_CONTROL_ENABLE_MODE_DIVIDER:
            begin
               next_rbyte[MODULE_ENABLE_BIT] = module_enable;
               next_rbyte[OUTPUT_LEVEL_STATUS_BIT] = timer_output;
               next_rbyte[WIDE_COUNTER_SELECT_BIT] = wide_counter_select;
               next_rbyte[OUTPUT_DIVIDER_LSB +: 4] = output_divider_select;
            end
            IDX_CONTROL_CLOCK_PRESCALE:
               next_rbyte = {clock_source_select, input_unsync_select, input_prescale_select};
            IDX_IRQ_CTRL:
            begin
               next_rbyte[IRQ_FLAG_BIT] = timer_irq_flag;
               next_rbyte[IRQ_ENABLE_BIT] = timer_irq_enable;
            end
            default: next_rbyte = 8'h00;
         endcase
      end
   end

   // Read data loads when the request is first seen, stands at the answer edge
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         avs_readdata <= 32'h0000_0000;
      else if (avs_read && !access_done)
         avs_readdata <= {24'h00_0000, next_rbyte};
   end
endmodule : timer0_output_postscaler_ctrl

/* bench/timer_sva.sv */
// Checker: bus handshake, read data and interrupt output relations
`timescale 1ns/1ps
module timer_sva (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [timer_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic sleep_mode,
   input wire logic timer_output,
   input wire logic timer_irq,
   input wire logic wake_request
);
   import timer_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ----------------------------------------
   // Bus handshake and read data
   // ----------------------------------------
   a_wait_answers: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
      else $error("request not answered within two cycles");
   a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer held longer than one cycle");
   a_wait_caused: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
      else $error("answer without a request");
   a_upper_zero: assert property (!avs_waitrequest && avs_read |-> avs_readdata[31:8] == 24'h0)
      else $error("upper read data not zero");
   a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0 |-> avs_readdata == 0)
      else $error("misaligned read returned data");
   a_status_level: assert property (avs_read && !avs_waitrequest &&
      avs_address == {IDX_CONTROL_ENABLE_MODE_DIVIDER, 2'b00} |-> avs_readdata[5] == $past(timer_output))
      else $error("status bit differs from timer output");
   // ----------------------------------------
   // Interrupt and wake outputs
   // ----------------------------------------
   a_wake_irq: assert property (wake_request |-> timer_irq)
      else $error("wake without interrupt");
   a_wake_sleep: assert property (wake_request |-> $past(sleep_mode))
      else $error("wake outside sleep");
endmodule : timer_sva
bind timer0_output_postscaler_ctrl timer_sva u_sva (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .sleep_mode(sleep_mode), .timer_output(timer_output), .timer_irq(timer_irq), .wake_request(wake_request));

/* bench/timer0_output_postscaler_ctrl_tb.sv */
// Testbench: register bus, counting modes, postscaler, sleep and interrupt
`timescale 1ns/1ps
module timer0_output_postscaler_ctrl_tb;
   import timer_pkg::*;
   logic ref_clk, rst, avs_read, avs_write, sleep_mode, avs_waitrequest, timer_output, timer_irq, wake_request;
   logic [ADDR_W-1:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, seed, rd;
   logic [3:0] avs_byteenable;
   logic last_out;
   clock_inputs_s clock_inputs;
   int failures, samples_checked, toggles, p, n, k, lv;
   timer0_output_postscaler_ctrl DUT (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .clock_inputs(clock_inputs),
      .sleep_mode(sleep_mode), .timer_output(timer_output), .timer_irq(timer_irq), .wake_request(wake_request));
   // ----------------------------------------
   // Clock, watchdog, monitors
   // ----------------------------------------
   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // Runs take under 6000 cycles; a hang is cut off well beyond that
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      conclude();
   end
   // Counted at the falling edge, clear of the output's own update
   always @(negedge ref_clk)
   begin
      if (timer_output !== last_out) toggles++;
      last_out = timer_output;
   end
   // Unselected sources carry noise, so a wrong decode would miscount
   always @(posedge ref_clk) clock_inputs[4:0] <= 5'(xs());
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Holds the request until waitrequest is low at a rising edge
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] addr, input logic [7:0] d);
      int w;
      w = 0;
      @(posedge ref_clk);
      avs_address <= addr;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= {24'h0, d};
      // Read just after the edge, waitrequest still shows its sampled value
      do
      begin
         @(posedge ref_clk);
         w++;
      end
      while (avs_waitrequest !== 1'b0 && w < 20);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (w >= 20) failures++;
   endtask : bus
   task automatic wreg(input logic [11:0] idx, input logic [7:0] d);
      bus(1'b1, {idx, 2'b00}, d);
   endtask : wreg
   task automatic rreg(input logic [11:0] idx);
      bus(1'b0, {idx, 2'b00}, 8'h00);
   endtask : rreg
   // Disabled while loading, so the period buffer takes the new value
   task automatic setup(input logic [7:0] c0, input logic [7:0] c1, input logic [7:0] hi, input logic [7:0] lo);
      wreg(IDX_CONTROL_ENABLE_MODE_DIVIDER, c0 & 8'h7F);
      wreg(IDX_CONTROL_CLOCK_PRESCALE, c1);
      wreg(IDX_COUNT_HIGH_PERIOD, hi);
      wreg(IDX_COUNT_LOW, lo);
      wreg(IDX_CONTROL_ENABLE_MODE_DIVIDER, c0);
      toggles = 0;
   endtask : setup
   // Pin pulses slower than the sync limit, then time to settle
   task automatic pulse(input int cnt);
      repeat (cnt)
      begin
         repeat (8) @(posedge ref_clk);
         clock_inputs.pin <= 1'b1;
         repeat (8) @(posedge ref_clk);
         clock_inputs.pin <= 1'b0;
      end
      repeat (12) @(posedge ref_clk);
   endtask : pulse
   task automatic conclude();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : conclude
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      seed = 32'd53;
      rst = 1'b1;
      {avs_read, avs_write, sleep_mode, last_out} = 4'h0;
      avs_address = '0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      clock_inputs = '0;
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      for (int i = 0; i < 5; i++)
      begin
         rreg(IDX_COUNT_LOW + 12'(i));
         check(rd, 32'h0);
      end
      bus(1'b0, 14'h3F49, 8'h00);
      check(rd, 32'h0);
      wreg(IDX_CONTROL_CLOCK_PRESCALE, 8'hF5);
      rreg(IDX_CONTROL_CLOCK_PRESCALE);
      check(rd, 32'hF5);
      avs_byteenable <= 4'h0;
      wreg(IDX_COUNT_HIGH_PERIOD, 8'h5A);
      avs_byteenable <= 4'hF;
      rreg(IDX_COUNT_HIGH_PERIOD);
      check(rd, 32'h0);
      wreg(IDX_CONTROL_ENABLE_MODE_DIVIDER, 8'h2F);
      rreg(IDX_CONTROL_ENABLE_MODE_DIVIDER);
      check(rd, 32'h0F);
      $display("test registers done");
      for (int i = 0; i < 4; i++)
      begin
         p = int'(xs() % 4) + 1;
         n = int'(xs() % 4);
         k = (p + 1) * (n + 1) * 2 + int'(xs() % 3);
         setup({4'h8, 4'(n)}, {3'(i % 2), 5'h00}, 8'(p), 8'h00);
         pulse(k);
         rreg(IDX_COUNT_LOW);
         check(rd, 32'(k % (p + 1)));
         check(toggles, k / (p + 1) / (n + 1));
         lv ^= (k / (p + 1) / (n + 1)) % 2;
      end
      $display("test period match done");
      setup(8'h80, 8'h02, 8'hFF, 8'h00);
      pulse(9);
      rreg(IDX_COUNT_LOW);
      check(rd, 32'h2);
      setup(8'h90, 8'h00, 8'hFF, 8'hFE);
      pulse(3);
      rreg(IDX_COUNT_LOW);
      check(rd, 32'h1);
      rreg(IDX_COUNT_HIGH_PERIOD);
      check(rd, 32'h0);
      check(toggles, 1);
      lv ^= 1;
      rreg(IDX_CONTROL_ENABLE_MODE_DIVIDER);
      check(rd, 32'h90 | (32'(lv) << 5));
      // Instruction clock source: one count per four system clocks
      setup(8'h80, 8'h40, 8'hFF, 8'h00);
      repeat (40) @(posedge ref_clk);
      rreg(IDX_COUNT_LOW);
      check(32'(rd > 8 && rd < 12), 32'h1);
      $display("test rollover done");
      setup(8'h80, 8'h00, 8'hFF, 8'h00);
      sleep_mode <= 1'b1;
      pulse(4);
      sleep_mode <= 1'b0;
      rreg(IDX_COUNT_LOW);
      check(rd, 32'h0);
      wreg(IDX_IRQ_CTRL, 8'h02);
      repeat (3) @(posedge ref_clk);
      check(timer_irq, 1'b0);
      setup(8'h80, 8'h10, 8'h01, 8'h00);
      sleep_mode <= 1'b1;
      pulse(2);
      check(wake_request, 1'b1);
      check(timer_irq, 1'b1);
      sleep_mode <= 1'b0;
      rreg(IDX_IRQ_CTRL);
      check(rd, 32'h3);
      wreg(IDX_IRQ_CTRL, 8'h02);
      repeat (3) @(posedge ref_clk);
      check(timer_irq, 1'b0);
      $display("test sleep and interrupt done");
      conclude();
   end
endmodule : timer0_output_postscaler_ctrl_tb
